// ---- hw/ptt_pkg.sv ----
package ptt_pkg;

    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_PRELOAD    = 8'h04;
    localparam logic [7:0]  ADDR_TIMER      = 8'h08;
    localparam logic [7:0]  ADDR_FLAGS      = 8'h0C;
    localparam logic [7:0]  ADDR_INT_MASK   = 8'h10;
    localparam logic [7:0]  ADDR_INT_CMP    = 8'h14;
    localparam logic [7:0]  ADDR_STATUS     = 8'h18;

    localparam int          CTRL_CFG_BIT    = 0;
    localparam int          CTRL_MODE_BIT   = 1;
    localparam int          CTRL_OFF_BIT    = 2;
    localparam int          FLAG_OVF_BIT    = 7;
    localparam int          STAT_RUN_BIT    = 0;
    localparam int          STAT_MODE_BIT   = 1;
    localparam int          STAT_INT_BIT    = 2;

    localparam logic [15:0] PRELOAD_RST     = 16'h0000;
    localparam logic [7:0]  MASK_RST        = 8'h00;
    localparam logic [7:0]  CMP_RST         = 8'h00;
    localparam logic [15:0] WORD_MAX        = 16'hFFFF;
    localparam int          MINOR_DIV       = 256;
    localparam logic [7:0]  MINOR_DIV_LAST  = 8'(MINOR_DIV - 1);

    typedef enum logic {
        PTT_MODE_TIMER,
        PTT_MODE_COUNT
    } ptt_mode_t;

    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ptt_apb_req_t;

    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
    } ptt_apb_rsp_t;

endpackage

// ---- hw/ptt_tick_div.sv ----
module ptt_tick_div (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic run_i,
    output logic      tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } ptt_div_state_t;

    ptt_div_state_t st_ff;
    ptt_div_state_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!run_i) begin
            nxt_st.cnt = 8'h00;
        end else if (st_ff.cnt == ptt_pkg::MINOR_DIV_LAST) begin
            nxt_st.cnt  = 8'h00;
            nxt_st.tick = 1'b1; // see R4 see R13
        end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;
endmodule

// ---- hw/ptt_edge_det.sv ----
module ptt_edge_det (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    output logic      rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } ptt_edge_state_t;

    ptt_edge_state_t st_ff;
    ptt_edge_state_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.s1   = pin_i;
        nxt_st.s2   = st_ff.s1;
        nxt_st.prev = st_ff.s2;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise_o = st_ff.s2 & ~st_ff.prev; // see R16
endmodule

// ---- hw/ptt_timer.sv ----
// Notes on behaviour
// R1 - timer or pin-0 counter mode; configure command starts chosen mode
// R2 - counter mode: hidden counter advances on each rising edge of pin 0
// R3 - counter mode: hidden counter wrap from 65535 bumps timer word
// R4 - timer mode: minor tick every 256 clocks advances hidden counter
// R5 - hidden counter wrap is a major tick that bumps timer word
// R6 - hidden counter reloads preload after each wrap
// R7 - timer word readable by software at any time
// R8 - timer word wrap from 65535 sets overflow flag
// R9 - configure clears overflow flag; writing zero also clears it
// R10 - overflow flag may drive the flag interrupt
// R11 - timer suspended while debug dump transmission runs
// R12 - software must not use servo generation while timer active
// R13 - clock rate change takes effect at once; tick scales with it
// R14 - flag is bit 7; interrupt when flags AND mask equals compare; code also needs a nonzero mask
// R15 - disable stops counting; reset leaves timer stopped, flag clear
// R16 - pin synchronised; rising edge found by registered sample compare
module ptt_timer (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  count_pin_i,
    input  wire logic                  dump_busy_i,
    input  wire logic [6:0]            other_flags_i,
    output logic                       flag_irq_o,
    output logic                       running_o
);
    typedef struct packed {
        logic                running;
        ptt_pkg::ptt_mode_t  mode;
        logic [15:0]         preload;
        logic [15:0]         minor;
        logic [15:0]         timer_word;
        logic                ovf;
        logic [7:0]          int_mask;
        logic [7:0]          int_cmp;
        ptt_pkg::ptt_apb_rsp_t rsp;
    } ptt_state_t;

    ptt_state_t            st_ff;
    ptt_state_t            nxt_st;
    ptt_pkg::ptt_apb_req_t req;
    logic                  tick;
    logic                  rise;
    logic                  advance;
    logic                  minor_wrap;
    logic                  word_wrap;
    logic                  wr_acc;
    logic                  rd_acc;
    logic [7:0]            flags_byte;
    logic                  flags_bit_seven;

    function automatic logic [15:0] ptt_merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                                input logic [3:0] strb);
        logic [15:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    assign req.sel   = psel_i;
    assign req.en    = penable_i;
    assign req.wr    = pwrite_i;
    assign req.addr  = paddr_i;
    assign req.wdata = pwdata_i;

    ptt_tick_div u_div (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .run_i  (st_ff.running && st_ff.mode == ptt_pkg::PTT_MODE_TIMER),
        .tick_o (tick)
    );

    ptt_edge_det u_edge (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .pin_i  (count_pin_i),
        .rise_o (rise)
    );

    // debug dump freezes both counters
    assign advance    = st_ff.running && !dump_busy_i &&                  // see R11 see R15
                        ((st_ff.mode == ptt_pkg::PTT_MODE_COUNT) ? rise : tick); // see R2 see R4
    assign minor_wrap = advance && (st_ff.minor == ptt_pkg::WORD_MAX);   // see R3 see R5
    assign word_wrap  = minor_wrap && (st_ff.timer_word == ptt_pkg::WORD_MAX);

    // writes land at the access edge, when pready is seen high
    assign wr_acc = req.sel && req.en && req.wr && st_ff.rsp.ready;
    assign rd_acc = req.sel && !req.en && !req.wr;

    assign flags_bit_seven = st_ff.ovf;
    assign flags_byte      = {flags_bit_seven, other_flags_i}; // see R14

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.rsp.ready  = 1'b0;
        nxt_st.rsp.slverr = 1'b0;

        if (advance) begin
            if (minor_wrap) begin
                nxt_st.minor      = st_ff.preload;            // see R6
                nxt_st.timer_word = st_ff.timer_word + 16'h0001; // see R3 see R5
            end else begin
                nxt_st.minor = st_ff.minor + 16'h0001;
            end
        end

        // setup phase arms the answer for the access cycle
        if (req.sel && !req.en && req.wr) begin
            nxt_st.rsp.ready  = 1'b1;
            nxt_st.rsp.slverr = (req.addr > ptt_pkg::ADDR_STATUS) || (req.addr[1:0] != 2'b00);
        end

        if (wr_acc) begin
            unique case (req.addr)
                ptt_pkg::ADDR_CTRL: begin
                    if (pstrb_i[0] && req.wdata[ptt_pkg::CTRL_OFF_BIT]) begin
                        nxt_st.running = 1'b0; // see R15
                    end else if (pstrb_i[0] && req.wdata[ptt_pkg::CTRL_CFG_BIT]) begin
                        nxt_st.running = 1'b1; // see R1
                        nxt_st.mode    = req.wdata[ptt_pkg::CTRL_MODE_BIT] ?
                                         ptt_pkg::PTT_MODE_COUNT : ptt_pkg::PTT_MODE_TIMER;
                        nxt_st.minor   = st_ff.preload;
                        nxt_st.ovf     = 1'b0; // see R9
                    end
                end
                ptt_pkg::ADDR_PRELOAD: begin
                    nxt_st.preload = ptt_merge16(st_ff.preload, req.wdata, pstrb_i);
                end
                ptt_pkg::ADDR_TIMER: begin
                    nxt_st.timer_word = ptt_merge16(st_ff.timer_word, req.wdata, pstrb_i);
                end
                ptt_pkg::ADDR_FLAGS: begin
                    if (pstrb_i[0] && !req.wdata[ptt_pkg::FLAG_OVF_BIT]) begin
                        nxt_st.ovf = 1'b0; // see R9
                    end
                end
                ptt_pkg::ADDR_INT_MASK: begin
                    if (pstrb_i[0]) begin
                        nxt_st.int_mask = req.wdata[7:0];
                    end
                end
                ptt_pkg::ADDR_INT_CMP: begin
                    if (pstrb_i[0]) begin
                        nxt_st.int_cmp = req.wdata[7:0];
                    end
                end
                ptt_pkg::ADDR_STATUS: begin
                end
                default: begin
                end
            endcase
        end

        // hardware set wins over any clear
        if (word_wrap) begin
            nxt_st.ovf = 1'b1; // see R8
        end

        if (rd_acc) begin
            nxt_st.rsp.ready = 1'b1;
            unique case (req.addr)
                ptt_pkg::ADDR_CTRL:     nxt_st.rsp.rdata = {29'h0, 1'b0, st_ff.mode == ptt_pkg::PTT_MODE_COUNT,
                                                            st_ff.running};
                ptt_pkg::ADDR_PRELOAD:  nxt_st.rsp.rdata = {16'h0, st_ff.preload};
                ptt_pkg::ADDR_TIMER:    nxt_st.rsp.rdata = {16'h0, st_ff.timer_word}; // see R7
                ptt_pkg::ADDR_FLAGS:    nxt_st.rsp.rdata = {24'h0, flags_byte};
                ptt_pkg::ADDR_INT_MASK: nxt_st.rsp.rdata = {24'h0, st_ff.int_mask};
                ptt_pkg::ADDR_INT_CMP:  nxt_st.rsp.rdata = {24'h0, st_ff.int_cmp};
                ptt_pkg::ADDR_STATUS:   nxt_st.rsp.rdata = {29'h0, flag_irq_o,
                                                            st_ff.mode == ptt_pkg::PTT_MODE_COUNT,
                                                            st_ff.running};
                default: begin
                    nxt_st.rsp.rdata  = 32'h0000_0000;
                    nxt_st.rsp.slverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff          <= '0; // see R15
            st_ff.preload  <= ptt_pkg::PRELOAD_RST;
            st_ff.int_mask <= ptt_pkg::MASK_RST;
            st_ff.int_cmp  <= ptt_pkg::CMP_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // nonzero mask needed so an unconfigured block stays quiet
    assign flag_irq_o = (st_ff.int_mask != 8'h00) &&
                        ((flags_byte & st_ff.int_mask) == st_ff.int_cmp); // see R10 see R14
    assign running_o  = st_ff.running;
    assign prdata_o   = st_ff.rsp.rdata;
    assign pready_o   = st_ff.rsp.ready && psel_i && penable_i;
    assign pslverr_o  = st_ff.rsp.slverr && psel_i && penable_i;
endmodule

// ---- bench/ptt_pulse_src.sv ----
module ptt_pulse_src (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] n_i,
    input  wire logic       slow_i,
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pin_o = 1'b0; // sole user of the timer, no servo traffic
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1) begin
                busy_o <= 1'b1;
                repeat (n_i) begin
                    pin_o <= 1'b1;
                    repeat (2) @(posedge clk_i);
                    pin_o <= 1'b0;
                    repeat (slow_i ? 9 : 2) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// ---- bench/ptt_timer_properties.sv ----
module ptt_timer_chk (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [6:0]  other_flags_i,
    input wire logic        flag_irq_o,
    input wire logic        running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic wr_ctrl;
    logic rd_done;
    assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == ptt_pkg::ADDR_CTRL;
    assign rd_done = pready_o && !pwrite_i;
    a_reset_stopped: assert property ($fell(srst_i) |-> !running_o && !flag_irq_o)
        else $error("not stopped after reset");
    a_read_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer in access cycle");
    a_unmapped_err: assert property (pready_o && (paddr_i > ptt_pkg::ADDR_STATUS || paddr_i[1:0] != 2'h0)
        |-> pslverr_o) else $error("unmapped address accepted");
    a_word_width: assert property (rd_done |-> prdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_flags_read: assert property (rd_done && paddr_i == ptt_pkg::ADDR_FLAGS |-> prdata_o[6:0] == $past(other_flags_i))
        else $error("flags byte low bits wrong");
    a_status_mirror: assert property (rd_done && paddr_i == ptt_pkg::ADDR_STATUS
        |-> prdata_o[2] == $past(flag_irq_o) && prdata_o[0] == $past(running_o)) else $error("status mismatch");
    a_cfg_start: assert property (wr_ctrl && pwdata_i[0] && !pwdata_i[2] |=> running_o)
        else $error("configure did not start");
    a_disable_stop: assert property (wr_ctrl && pwdata_i[2] |=> !running_o)
        else $error("disable did not stop");
    a_run_steady: assert property (!wr_ctrl |=> $stable(running_o))
        else $error("run state changed without command");
endmodule
bind ptt_timer ptt_timer_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .other_flags_i(other_flags_i), .flag_irq_o(flag_irq_o), .running_o(running_o));

// ---- bench/ptt_timer_tb_top.sv ----
module ptt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } ptt_row_t;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, dump = 1'b0, go = 1'b0, slow = 1'b0;
    logic        rdy, err, pin, irq, run, bsy, e;
    logic [7:0]  addr = 8'h00, npulse = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [6:0]  oflags = 7'h55;
    int          err_count = 0, n_compared = 0, cyc = 0;
    ptt_row_t    rows [9] = '{'{1'b0, ptt_pkg::ADDR_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, ptt_pkg::ADDR_PRELOAD, 32'h0, 32'h0, 1'b0}, '{1'b0, ptt_pkg::ADDR_TIMER, 32'h0, 32'h0, 1'b0},
        '{1'b0, ptt_pkg::ADDR_FLAGS, 32'h0, 32'h55, 1'b0}, '{1'b0, ptt_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0},
        '{1'b1, ptt_pkg::ADDR_PRELOAD, 32'h1234ABCD, 32'hABCD, 1'b0},
        '{1'b1, ptt_pkg::ADDR_INT_MASK, 32'h1FF, 32'hFF, 1'b0},
        '{1'b1, ptt_pkg::ADDR_STATUS, 32'h7, 32'h0, 1'b0}, '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1}};
    ptt_timer u_ptt_timer (.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(addr), .pwdata_i(wdata), .pstrb_i(4'hF), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err),
        .count_pin_i(pin), .dump_busy_i(dump), .other_flags_i(oflags), .flag_irq_o(irq), .running_o(run));
    ptt_pulse_src u_ptt_pulse_src (.clk_i(clk), .go_i(go), .n_i(npulse), .slow_i(slow), .pin_o(pin),
        .busy_o(bsy));
    initial forever #25 clk = ~clk;
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rdata;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic pulses(input logic [7:0] n, input logic s);
        @(posedge clk);
        npulse <= n;
        slow <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(negedge clk); while (bsy === 1'b1);
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].x);
            chk(32'(e), 32'(rows[i].e));
        end
        wr(ptt_pkg::ADDR_INT_MASK, 32'h80);
        wr(ptt_pkg::ADDR_INT_CMP, 32'h80);
        wr(ptt_pkg::ADDR_PRELOAD, 32'hFFFF);
        wr(ptt_pkg::ADDR_TIMER, 32'hFFFF);
        wr(ptt_pkg::ADDR_CTRL, 32'h1);
        repeat (240) @(posedge clk);
        rd(ptt_pkg::ADDR_TIMER, 32'hFFFF);
        repeat (30) @(posedge clk);
        rd(ptt_pkg::ADDR_TIMER, 32'h0);
        rd(ptt_pkg::ADDR_FLAGS, 32'hD5);
        chk(32'(irq), 32'h1);
        wr(ptt_pkg::ADDR_FLAGS, 32'h0);
        rd(ptt_pkg::ADDR_FLAGS, 32'h55);
        chk(32'(irq), 32'h0);
        dump <= 1'b1;
        repeat (600) @(posedge clk);
        rd(ptt_pkg::ADDR_TIMER, 32'h0);
        dump <= 1'b0;
        repeat (260) @(posedge clk);
        rd(ptt_pkg::ADDR_TIMER, 32'h1);
        wr(ptt_pkg::ADDR_TIMER, 32'hFFFF);
        repeat (260) @(posedge clk);
        rd(ptt_pkg::ADDR_FLAGS, 32'hD5);
        wr(ptt_pkg::ADDR_CTRL, 32'h1);
        rd(ptt_pkg::ADDR_FLAGS, 32'h55);
        wr(ptt_pkg::ADDR_CTRL, 32'h5);
        wr(ptt_pkg::ADDR_TIMER, 32'h7);
        repeat (300) @(posedge clk);
        rd(ptt_pkg::ADDR_TIMER, 32'h7);
        wr(ptt_pkg::ADDR_PRELOAD, 32'hFFFD);
        wr(ptt_pkg::ADDR_TIMER, 32'h0);
        wr(ptt_pkg::ADDR_CTRL, 32'h3);
        rd(ptt_pkg::ADDR_STATUS, 32'h3);
        pulses(8'h07, 1'b0);
        rd(ptt_pkg::ADDR_TIMER, 32'h2);
        pulses(8'h02, 1'b1);
        rd(ptt_pkg::ADDR_TIMER, 32'h3);
        wr(ptt_pkg::ADDR_CTRL, 32'h4);
        pulses(8'h03, 1'b0);
        rd(ptt_pkg::ADDR_TIMER, 32'h3);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(ptt_pkg::ADDR_CTRL, 32'h0);
        complete_run();
    end
endmodule
